// ### adc_status_pkg.sv
package adc_status_pkg;

    // register offsets on the device register port
    localparam logic [7:0]  STATUS_OFFSET   = 8'h21;
    localparam logic [7:0]  CTRL_ONE_OFFSET = 8'h22;
    localparam logic [7:0]  CTRL_TWO_OFFSET = 8'h23;
    localparam logic [7:0]  RESULT_OFFSET   = 8'h24;

    // field positions in the status word
    localparam int REF_PRESENT_BIT = 14;
    localparam int DIG_OVER_BIT    = 9;
    localparam int ANA_OVER_BIT    = 8;
    localparam int RATE_LSB        = 4;
    localparam int PD_STATE_LSB    = 2;
    localparam int MOD_ACTIVE_BIT  = 1;
    localparam int READY_BIT       = 0;

    // field positions in the control words
    localparam int PD_TYPE_BIT     = 20;
    localparam int NO_LATENCY_BIT  = 17;
    localparam int REPEAT_NL_BIT   = 16;
    localparam int EXT_CLOCK_BIT   = 23;
    localparam int SYNC_ENABLE_BIT = 21;
    localparam int GAIN_BYP_BIT    = 19;
    localparam int OFFSET_BYP_BIT  = 18;

    // writable bits; everything else is reserved and reads zero
    localparam logic [23:0] CTRL_ONE_MASK  = 24'h130000;
    localparam logic [23:0] CTRL_TWO_MASK  = 24'hAC0000;

    // values after reset
    localparam logic [23:0] CTRL_ONE_RESET = 24'h020000;
    localparam logic [23:0] CTRL_TWO_RESET = 24'h000000;
    localparam logic [23:0] RESULT_RESET   = 24'h000000;
    localparam logic [3:0]  RATE_RESET     = 4'h0;

    // power-down state codes
    localparam logic [1:0]  PD_CONVERTING  = 2'h0;
    localparam logic [1:0]  PD_STANDBY     = 2'h2;
    localparam logic [1:0]  PD_IN_RESET    = 2'h3;

    // reference detect threshold in millivolts
    localparam logic [11:0] REF_THRESH_MV  = 12'h15E;

    // calibration values forced by the bypass bits
    localparam logic [23:0] GAIN_UNITY     = 24'h800000;
    localparam logic [23:0] OFFSET_ZERO    = 24'h000000;

    // two's complement result limits
    localparam logic [23:0] RESULT_MAX     = 24'h7FFFFF;
    localparam logic [23:0] RESULT_MIN     = 24'h800000;

endpackage

// ### sample_capture.sv
`timescale 1ns/100ps
module sample_capture
    import adc_status_pkg::*;
#(
    parameter int RAW_W = 26
) (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    sample_valid,
    input  wire logic signed [RAW_W-1:0] sample_raw,
    input  wire logic [3:0]              sample_rate,
    input  wire logic                    analog_over,
    output logic [23:0]                  result_ff,
    output logic [3:0]                   rate_ff,
    output logic                         dig_over_ff,
    output logic                         ana_over_ff
);

    logic signed [RAW_W-1:0] max_ext;
    logic signed [RAW_W-1:0] min_ext;
    logic                    too_high;
    logic                    too_low;
    logic [23:0]             nxt_result;
    logic [3:0]              nxt_rate;
    logic                    nxt_dig_over;
    logic                    nxt_ana_over;

    // clamp compare against sign-extended limits
    assign max_ext  = RAW_W'(signed'(RESULT_MAX));
    assign min_ext  = RAW_W'(signed'(RESULT_MIN));
    assign too_high = sample_raw > max_ext;
    assign too_low  = sample_raw < min_ext;

    // result, rate tag and overrange flags move only with a new sample
    always_comb begin
        nxt_result   = result_ff;
        nxt_rate     = rate_ff;
        nxt_dig_over = dig_over_ff;
        nxt_ana_over = ana_over_ff;
        if (sample_valid) begin // RQ3
            nxt_rate     = sample_rate; // RQ5
            nxt_ana_over = analog_over; // RQ4
            nxt_dig_over = too_high | too_low; // RQ2
            if (too_high) begin
                nxt_result = RESULT_MAX; // RQ2
            end else if (too_low) begin
                nxt_result = RESULT_MIN; // RQ2
            end else begin
                nxt_result = sample_raw[23:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            result_ff   <= RESULT_RESET;
            rate_ff     <= RATE_RESET;
            dig_over_ff <= 1'b0;
            ana_over_ff <= 1'b0;
        end else begin
            result_ff   <= nxt_result;
            rate_ff     <= nxt_rate;
            dig_over_ff <= nxt_dig_over;
            ana_over_ff <= nxt_ana_over;
        end
    end

endmodule

// ### adc_channel_status_control.sv
// Contract
// RQ1: reference present flag, bit 14, set while reference exceeds 350 mV
// RQ2: out-of-range result sets digital overrange, bit 9, and clamps to min/max
// RQ3: both overrange flags change only when a new sample becomes ready
// RQ4: analog overrange flag, bit 8, marks the latest result possibly corrupted
// RQ5: status bits 7:4 carry the rate code of the held result
// RQ6: power-down field 3:2: 00 converting, 10 standby, 11 reset
// RQ7: modulator active flag, bit 1, follows the modulator converting
// RQ8: host allows up to 2 us lag of the modulator flag
// RQ9: ready flag, bit 0, set on new result, cleared by result read
// RQ10: write changing any writable control bit aborts the conversion
// RQ11: control one bit 20 picks standby (0) or reset (1) power-down
// RQ12: bit 17 picks no-latency mode; bit 16 repeats it, only then
// RQ13: control two bit 23 picks internal (0) or external (1) clock
// RQ14: control two bit 21 enables external sync when 1
// RQ15: control two bit 19 forces gain coefficient to 800000h
// RQ16: control two bit 18 forces offset coefficient to zero
`timescale 1ns/100ps
module adc_channel_status_control
    import adc_status_pkg::*;
#(
    parameter int RAW_W = 26
) (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic [7:0]              reg_addr,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire logic [23:0]             reg_wdata,
    output logic [23:0]                  reg_rdata_ff,
    input  wire logic                    sample_valid,
    input  wire logic signed [RAW_W-1:0] sample_raw,
    input  wire logic [3:0]              sample_rate,
    input  wire logic                    analog_over,
    input  wire logic [11:0]             ref_level_mv,
    input  wire logic                    modulator_busy,
    input  wire logic                    adc_converting,
    input  wire logic [23:0]             sys_gain_coef,
    input  wire logic [23:0]             sys_offset_coef,
    output logic                         conversion_abort_ff,
    output logic                         powerdown_type_select,
    output logic                         no_latency_mode_select,
    output logic                         repeat_no_latency_select,
    output logic                         external_clock_select,
    output logic                         sync_enable_select,
    output logic                         gain_correction_bypass,
    output logic                         offset_correction_bypass,
    output logic [23:0]                  gain_coef_ff,
    output logic [23:0]                  offset_coef_ff
);

    logic [23:0] ctrl_one_ff;
    logic [23:0] ctrl_two_ff;
    logic        ready_ff;
    logic        ref_present_ff;
    logic        mod_active_ff;
    logic [1:0]  pd_state_ff;
    logic [23:0] nxt_ctrl_one;
    logic [23:0] nxt_ctrl_two;
    logic        nxt_ready;
    logic        nxt_ref_present;
    logic        nxt_mod_active;
    logic [1:0]  nxt_pd_state;
    logic        nxt_abort;
    logic [23:0] nxt_rdata;
    logic [23:0] nxt_gain_coef;
    logic [23:0] nxt_offset_coef;
    logic [23:0] result_ff;
    logic [3:0]  rate_ff;
    logic        dig_over_ff;
    logic        ana_over_ff;
    logic [23:0] status_word;
    logic        wr_one;
    logic        wr_two;
    logic        rd_result;

    // result, rate tag and overrange flags
    sample_capture #(
        .RAW_W (RAW_W)
    ) u_capture (
        .clk          (clk),
        .rstn         (rstn),
        .sample_valid (sample_valid),
        .sample_raw   (sample_raw),
        .sample_rate  (sample_rate),
        .analog_over  (analog_over),
        .result_ff    (result_ff),
        .rate_ff      (rate_ff),
        .dig_over_ff  (dig_over_ff),
        .ana_over_ff  (ana_over_ff)
    );

    assign wr_one    = reg_wr && (reg_addr == CTRL_ONE_OFFSET);
    assign wr_two    = reg_wr && (reg_addr == CTRL_TWO_OFFSET);
    assign rd_result = reg_rd && (reg_addr == RESULT_OFFSET);

    // status word assembly, reserved bits zero
    always_comb begin
        status_word                  = 24'h000000;
        status_word[REF_PRESENT_BIT] = ref_present_ff;
        status_word[DIG_OVER_BIT]    = dig_over_ff;
        status_word[ANA_OVER_BIT]    = ana_over_ff;
        status_word[RATE_LSB+:4]     = rate_ff; // RQ5
        status_word[PD_STATE_LSB+:2] = pd_state_ff;
        status_word[MOD_ACTIVE_BIT]  = mod_active_ff;
        status_word[READY_BIT]       = ready_ff;
    end

    // control bits steer the converter
    assign powerdown_type_select    = ctrl_one_ff[PD_TYPE_BIT]; // RQ11
    assign no_latency_mode_select   = ctrl_one_ff[NO_LATENCY_BIT]; // RQ12
    assign repeat_no_latency_select = ctrl_one_ff[REPEAT_NL_BIT] & ctrl_one_ff[NO_LATENCY_BIT]; // RQ12
    assign external_clock_select    = ctrl_two_ff[EXT_CLOCK_BIT]; // RQ13
    assign sync_enable_select       = ctrl_two_ff[SYNC_ENABLE_BIT]; // RQ14
    assign gain_correction_bypass   = ctrl_two_ff[GAIN_BYP_BIT];
    assign offset_correction_bypass = ctrl_two_ff[OFFSET_BYP_BIT];

    // next values of control, status and read data
    always_comb begin
        nxt_ctrl_one    = ctrl_one_ff;
        nxt_ctrl_two    = ctrl_two_ff;
        nxt_abort       = 1'b0;
        if (wr_one) begin
            nxt_ctrl_one = reg_wdata & CTRL_ONE_MASK;
            nxt_abort    = ((reg_wdata ^ ctrl_one_ff) & CTRL_ONE_MASK) != 24'h000000; // RQ10
        end
        if (wr_two) begin
            nxt_ctrl_two = reg_wdata & CTRL_TWO_MASK;
            nxt_abort    = ((reg_wdata ^ ctrl_two_ff) & CTRL_TWO_MASK) != 24'h000000; // RQ10
        end
        // new sample wins over a same-cycle read
        nxt_ready = ready_ff;
        if (rd_result) begin
            nxt_ready = 1'b0; // RQ9
        end
        if (sample_valid) begin
            nxt_ready = 1'b1; // RQ9
        end
        nxt_ref_present = ref_level_mv > REF_THRESH_MV; // RQ1
        nxt_mod_active  = modulator_busy; // RQ7
        if (adc_converting) begin
            nxt_pd_state = PD_CONVERTING; // RQ6
        end else if (ctrl_one_ff[PD_TYPE_BIT]) begin
            nxt_pd_state = PD_IN_RESET; // RQ6
        end else begin
            nxt_pd_state = PD_STANDBY; // RQ6
        end
        nxt_gain_coef   = ctrl_two_ff[GAIN_BYP_BIT] ? GAIN_UNITY : sys_gain_coef; // RQ15
        nxt_offset_coef = ctrl_two_ff[OFFSET_BYP_BIT] ? OFFSET_ZERO : sys_offset_coef; // RQ16
        nxt_rdata = 24'h000000;
        if (reg_rd) begin
            if (reg_addr == STATUS_OFFSET) begin
                nxt_rdata = status_word;
            end else if (reg_addr == CTRL_ONE_OFFSET) begin
                nxt_rdata = ctrl_one_ff;
            end else if (reg_addr == CTRL_TWO_OFFSET) begin
                nxt_rdata = ctrl_two_ff;
            end else if (reg_addr == RESULT_OFFSET) begin
                nxt_rdata = result_ff;
            end else begin
                nxt_rdata = 24'h000000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_one_ff         <= CTRL_ONE_RESET;
            ctrl_two_ff         <= CTRL_TWO_RESET;
            ready_ff            <= 1'b0;
            ref_present_ff      <= 1'b0;
            mod_active_ff       <= 1'b0;
            pd_state_ff         <= PD_STANDBY;
            conversion_abort_ff <= 1'b0;
            reg_rdata_ff        <= 24'h000000;
            gain_coef_ff        <= GAIN_UNITY;
            offset_coef_ff      <= OFFSET_ZERO;
        end else begin
            ctrl_one_ff         <= nxt_ctrl_one;
            ctrl_two_ff         <= nxt_ctrl_two;
            ready_ff            <= nxt_ready;
            ref_present_ff      <= nxt_ref_present;
            mod_active_ff       <= nxt_mod_active;
            pd_state_ff         <= nxt_pd_state;
            conversion_abort_ff <= nxt_abort;
            reg_rdata_ff        <= nxt_rdata;
            gain_coef_ff        <= nxt_gain_coef;
            offset_coef_ff      <= nxt_offset_coef;
        end
    end

    // checks on the block's own registers and outputs
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_read_status;
        reg_rd && reg_addr == STATUS_OFFSET;
    endsequence

    sequence s_high_sample;
        sample_valid && sample_raw > RAW_W'(signed'(RESULT_MAX));
    endsequence

    property p_ref_detect;
        ##1 s_read_status ##1 1 |-> $past(ref_level_mv, 2) > REF_THRESH_MV
            == reg_rdata_ff[REF_PRESENT_BIT];
    endproperty
    a_ref_detect: assert property (p_ref_detect) else $error("reference flag wrong"); // RQ1

    property p_clamp_high;
        s_high_sample ##1 s_read_status |=> reg_rdata_ff[DIG_OVER_BIT];
    endproperty
    a_clamp_high: assert property (p_clamp_high) else $error("overrange not flagged"); // RQ2

    property p_clamp_value;
        s_high_sample |=> result_ff == RESULT_MAX && dig_over_ff;
    endproperty
    a_clamp_value: assert property (p_clamp_value) else $error("result not clamped"); // RQ2

    property p_flags_hold;
        !sample_valid |=> $stable(dig_over_ff) && $stable(ana_over_ff);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("overrange moved without sample"); // RQ3

    property p_analog_over;
        sample_valid |=> ana_over_ff == $past(analog_over);
    endproperty
    a_analog_over: assert property (p_analog_over) else $error("analog overrange wrong"); // RQ4

    property p_rate_tag;
        sample_valid ##1 s_read_status |=> reg_rdata_ff[RATE_LSB+:4] == $past(sample_rate, 2);
    endproperty
    a_rate_tag: assert property (p_rate_tag) else $error("rate tag wrong"); // RQ5

    property p_pd_state;
        !adc_converting && powerdown_type_select |=> pd_state_ff == PD_IN_RESET;
    endproperty
    a_pd_state: assert property (p_pd_state) else $error("power-down code wrong"); // RQ6

    property p_pd_legal;
        pd_state_ff != 2'h1;
    endproperty
    a_pd_legal: assert property (p_pd_legal) else $error("reserved power-down code"); // RQ6

    property p_mod_active;
        modulator_busy [*2] |-> mod_active_ff;
    endproperty
    a_mod_active: assert property (p_mod_active) else $error("modulator flag lags"); // RQ7

    property p_ready_set;
        sample_valid |=> ready_ff;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set"); // RQ9

    property p_ready_clear;
        rd_result && !sample_valid |=> !ready_ff;
    endproperty
    a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared"); // RQ9

    property p_abort;
        wr_one && ((reg_wdata ^ ctrl_one_ff) & CTRL_ONE_MASK) != 24'h000000
            |=> conversion_abort_ff ##1 !conversion_abort_ff || $past(reg_wr);
    endproperty
    a_abort: assert property (p_abort) else $error("abort missing"); // RQ10

    property p_no_abort;
        !reg_wr |=> !conversion_abort_ff;
    endproperty
    a_no_abort: assert property (p_no_abort) else $error("spurious abort"); // RQ10

    property p_gain_bypass;
        gain_correction_bypass |=> gain_coef_ff == GAIN_UNITY;
    endproperty
    a_gain_bypass: assert property (p_gain_bypass) else $error("gain not forced"); // RQ15

    property p_offset_bypass;
        offset_correction_bypass |=> offset_coef_ff == OFFSET_ZERO;
    endproperty
    a_offset_bypass: assert property (p_offset_bypass) else $error("offset not forced"); // RQ16

endmodule

// ### host_port.sv
`timescale 1ns/100ps
// host side of the register port: one strobe per access, idle edge between
module host_port (
    input  wire logic        clk,
    output logic [7:0]       reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [23:0]      reg_wdata,
    input  wire logic [23:0] reg_rdata_ff
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 24'h000000;
    end

    // write held over one taking edge, data scrambled once released
    task automatic wr(input logic [7:0] a, input logic [23:0] dat);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = dat;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~dat;
    endtask

    // read data taken 1 ns after the taking edge
    task automatic rd(input logic [7:0] a, output logic [23:0] dat);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        dat = reg_rdata_ff;
    endtask
endmodule

// ### tb_top.sv
`timescale 1ns/100ps
module tb_top
    import adc_status_pkg::*;
;
    logic               clk, rstn, reg_wr, reg_rd, sample_valid, analog_over;
    logic [7:0]         reg_addr;
    logic [23:0]        reg_wdata, reg_rdata_ff, sys_gain_coef, sys_offset_coef, d;
    logic signed [25:0] sample_raw;
    logic [3:0]         sample_rate;
    logic [11:0]        ref_level_mv;
    logic               modulator_busy, adc_converting, abrt, pdt, nl, rep;
    logic               ext, syn, gb, ob;
    logic [23:0]        gain_c, off_c;
    int                 fail_count, tests_run;
    // host polling lag allowance for the modulator flag, 2 us at 10 ns a cycle
    localparam int      MOD_LAG_CYCLES = 200;

    host_port host_port_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff));

    adc_channel_status_control #(.RAW_W(26)) adc_channel_status_control_i (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
        .sample_valid(sample_valid), .sample_raw(sample_raw),
        .sample_rate(sample_rate), .analog_over(analog_over),
        .ref_level_mv(ref_level_mv), .modulator_busy(modulator_busy),
        .adc_converting(adc_converting), .sys_gain_coef(sys_gain_coef),
        .sys_offset_coef(sys_offset_coef), .conversion_abort_ff(abrt),
        .powerdown_type_select(pdt), .no_latency_mode_select(nl),
        .repeat_no_latency_select(rep), .external_clock_select(ext),
        .sync_enable_select(syn), .gain_correction_bypass(gb),
        .offset_correction_bypass(ob), .gain_coef_ff(gain_c), .offset_coef_ff(off_c));

    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // compare and count
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (fail_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // values after reset, unmapped read
    task automatic t_reset();
        host_port_i.rd(8'h21, d);
        chk(d, 24'h000008);
        host_port_i.rd(8'h22, d);
        chk(d, 24'h020000);
        host_port_i.rd(8'h23, d);
        chk(d, 24'h000000);
        host_port_i.rd(8'h24, d);
        chk(d, 24'h000000);
        host_port_i.rd(8'h30, d);
        chk(d, 24'h000000);
        chk(gain_c, 24'h123456);
        chk(off_c, 24'h000321);
        chk({23'h0, abrt}, 24'h000000);
    endtask

    // one sample, status read on the very next edge, result, ready cleared
    task automatic t_smp(input logic [25:0] raw, input logic [3:0] rt, input logic ao,
                         input logic [23:0] es, input logic [23:0] er);
        @(posedge clk);
        #1;
        sample_valid = 1'b1;
        sample_raw = raw;
        sample_rate = rt;
        analog_over = ao;
        // status read raised as the sample pulse drops; inputs scrambled after
        fork
            host_port_i.rd(8'h21, d);
            begin
                @(posedge clk);
                #1;
                sample_valid = 1'b0;
                sample_rate = ~rt;
                analog_over = ~ao;
            end
        join
        chk(d, es);
        host_port_i.rd(8'h24, d);
        chk(d, er);
        host_port_i.rd(8'h21, d);
        chk(d, es & 24'hFFFFFE);
    endtask

    // reference, modulator and conversion levels
    task automatic t_levels();
        ref_level_mv = 12'h15E;
        host_port_i.rd(8'h21, d);
        chk(d & 24'h004000, 24'h000000);
        ref_level_mv = 12'h15F;
        host_port_i.rd(8'h21, d);
        chk(d & 24'h004000, 24'h004000);
        modulator_busy = 1'b1;
        // poll only after the flag has had time to follow
        repeat (MOD_LAG_CYCLES) @(posedge clk);
        host_port_i.rd(8'h21, d);
        chk(d & 24'h000002, 24'h000002);
        modulator_busy = 1'b0;
        repeat (MOD_LAG_CYCLES) @(posedge clk);
        host_port_i.rd(8'h21, d);
        chk(d & 24'h000002, 24'h000000);
        adc_converting = 1'b1;
        host_port_i.rd(8'h21, d);
        chk(d & 24'h00000C, 24'h000000);
        adc_converting = 1'b0;
    endtask

    // control writes, abort only on change, reserved bits dropped
    task automatic t_ctrl();
        host_port_i.wr(8'h22, 24'h130000);
        chk({23'h0, abrt}, 24'h000001);
        chk({21'h0, pdt, nl, rep}, 24'h000007);
        host_port_i.rd(8'h21, d);
        chk(d & 24'h00000C, 24'h00000C);
        host_port_i.wr(8'h22, 24'h130000);
        chk({23'h0, abrt}, 24'h000000);
        host_port_i.wr(8'h22, 24'hC90000);
        chk({23'h0, abrt}, 24'h000001);
        chk({22'h0, nl, rep}, 24'h000000);
        host_port_i.rd(8'h22, d);
        chk(d, 24'h010000);
        host_port_i.wr(8'h23, 24'hFFFFFF);
        chk({23'h0, abrt}, 24'h000001);
        chk({20'h0, ext, syn, gb, ob}, 24'h00000F);
        host_port_i.rd(8'h23, d);
        chk(d, 24'hAC0000);
        chk(gain_c, 24'h800000);
        chk(off_c, 24'h000000);
        host_port_i.wr(8'h21, 24'hFFFFFF);
        chk({23'h0, abrt}, 24'h000000);
        host_port_i.wr(8'h23, 24'h000000);
        @(posedge clk);
        #1;
        chk(gain_c, 24'h123456);
        chk(off_c, 24'h000321);
    endtask

    // watchdog
    initial begin
        #200000;
        fail_count++;
        close_out();
    end

    // main sequence
    initial begin
        fail_count = 0;
        tests_run = 0;
        rstn = 1'b0;
        sample_valid = 1'b0;
        sample_raw = '0;
        sample_rate = 4'h0;
        analog_over = 1'b0;
        ref_level_mv = 12'h000;
        modulator_busy = 1'b0;
        adc_converting = 1'b0;
        sys_gain_coef = 24'h123456;
        sys_offset_coef = 24'h000321;
        repeat (16) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_reset();
        t_smp(26'h0800000, 4'hA, 1'b1, 24'h0003A9, 24'h7FFFFF);
        t_smp(26'h37FFFFF, 4'h5, 1'b0, 24'h000259, 24'h800000);
        t_smp(26'h07FFFFF, 4'h3, 1'b1, 24'h000139, 24'h7FFFFF);
        t_levels();
        t_ctrl();
        close_out();
    end
endmodule
